// ==== design/acj_config.sv ====
// acj_config: apb register file plus the per-channel sample path and the
// serial-link transmit sequencing it steers.
// assumes: one 125 MHz clock; converter samples and sync/pins arrive async.
//
// Design decisions made here: the placing of the registers and the APB register port.
`timescale 1ns/1ps
`default_nettype none
module acj_config
  import acj_pkg::*;
(
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  // apb slave
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [ADDR_W-1:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // pins and converter
  input wire logic power_down_pin_i,
  input wire logic sync_n_i,
  input wire logic [NUM_CH*SMP_W-1:0] adc_data_i,
  input wire logic [NUM_CH-1:0] adc_ovr_i,
  // control outputs
  output logic chip_pd_o,
  output logic [NUM_CH-1:0] ch_standby_o,
  output logic sysref_buf_en_o,
  output logic low_freq_o,
  output logic sample_en_o,
  output logic [NUM_CH-1:0] dither_en_o,
  output logic [NUM_CH-1:0] chopper_en_o,
  // sample and link outputs
  output logic [NUM_CH*SMP_W-1:0] smp_o,
  output logic [NUM_CH*SMP_W-1:0] lane_bits_o,
  output logic [7:0] idle_char_o,
  output logic send_idle_o,
  output logic send_ila_o,
  output logic align_chars_en_o,
  output logic scramble_en_o,
  output logic [1:0] subclass_o,
  output logic [4:0] k_o,
  output logic [4:0] f_o
);

  // ----------------------------------------------------------------
  // apb access
  // ----------------------------------------------------------------
  logic wr_en;
  logic rd_en;
  logic known;
  assign wr_en = psel_i && penable_i && pwrite_i;
  assign rd_en = psel_i && penable_i && !pwrite_i;
  assign known = (paddr_i == OFS_COMMON) || (paddr_i == OFS_CHAN) || (paddr_i == OFS_GAIN) ||
                 (paddr_i == OFS_TEST) || (paddr_i == OFS_LINK) || (paddr_i == OFS_FRAME) ||
                 (paddr_i == OFS_STATUS);

  // ----------------------------------------------------------------
  // settings
  // ----------------------------------------------------------------
  acj_common_t cmn;
  acj_link_t lnk;
  logic soft_rst;
  logic [NUM_CH-1:0] dither_off;
  logic [NUM_CH-1:0] chop_off;
  logic [NUM_CH-1:0] ch_pd;
  logic [NUM_CH-1:0] gain_en;
  logic [NUM_CH*GAIN_W-1:0] gain;
  logic [SMP_W-1:0] custom;
  logic [NUM_CH*PAT_W-1:0] pat_sel;
  logic test_en;
  logic align;
  logic cfg_rst;
  // soft reset lasts one cycle after the write, so the bit self clears
  assign cfg_rst = !rst_n_i || soft_rst;

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      soft_rst <= 1'b0;
    end else begin
      soft_rst <= wr_en && pready_o && paddr_i == OFS_COMMON && pwdata_i[B_SOFT_RESET];
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (cfg_rst) begin
      cmn <= '0;
      cmn.clk_div <= CLK_DIV_RST;
    end else if (wr_en && paddr_i == OFS_COMMON) begin
      cmn.global_pd <= pwdata_i[B_GLOBAL_PD];
      cmn.standby <= pwdata_i[B_STANDBY];
      cmn.pin_is_standby <= pwdata_i[B_PIN_IS_STANDBY];
      cmn.offset_bin <= pwdata_i[B_OFFSET_BIN];
      cmn.sysref_off <= pwdata_i[B_SYSREF_OFF];
      cmn.low_freq <= pwdata_i[B_LOW_FREQ];
      cmn.ovr_lsb <= pwdata_i[B_OVR_LSB];
      cmn.clk_div <= pwdata_i[F_CLK_DIV +: CLK_DIV_W];
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (cfg_rst) begin
      dither_off <= '0;
      chop_off <= '0;
      ch_pd <= '0;
      gain_en <= '0;
      gain <= '0;
    end else if (wr_en && paddr_i == OFS_CHAN) begin
      dither_off <= pwdata_i[F_DITHER_OFF +: NUM_CH];
      chop_off <= pwdata_i[F_CHOP_OFF +: NUM_CH];
      ch_pd <= pwdata_i[F_CH_PD +: NUM_CH];
      gain_en <= pwdata_i[F_GAIN_EN +: NUM_CH];
    end else if (wr_en && paddr_i == OFS_GAIN) begin
      gain <= pwdata_i[NUM_CH*GAIN_W-1:0];
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (cfg_rst) begin
      custom <= '0;
      pat_sel <= '0;
      test_en <= 1'b0;
      align <= 1'b0;
    end else if (wr_en && paddr_i == OFS_TEST) begin
      custom <= pwdata_i[F_CUSTOM +: SMP_W];
      pat_sel <= pwdata_i[F_PAT_SEL +: NUM_CH*PAT_W];
      test_en <= pwdata_i[B_TEST_EN];
      align <= pwdata_i[B_ALIGN];
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (cfg_rst) begin
      lnk <= '0;
      lnk.idle <= IDLE_K28_5;
      lnk.subclass <= SUBCLASS_RST;
      lnk.k_val <= K_DEFAULT;
      lnk.f_val <= F_DEFAULT;
    end else if (wr_en && paddr_i == OFS_LINK) begin
      lnk.idle <= pwdata_i[F_IDLE +: 8];
      lnk.msb_first <= pwdata_i[B_MSB_FIRST];
      lnk.skip_ila <= pwdata_i[B_SKIP_ILA];
      lnk.align_chars <= pwdata_i[B_ALIGN_CHARS];
      lnk.scramble <= pwdata_i[B_SCRAMBLE];
      lnk.subclass <= pwdata_i[F_SUBCLASS +: 2];
      lnk.ila_delay <= pwdata_i[F_ILA_DELAY +: 2];
      lnk.k_ovr <= pwdata_i[B_K_OVR];
      lnk.f_ovr <= pwdata_i[B_F_OVR];
      lnk.sync_req <= pwdata_i[B_SYNC_REQ];
    end else if (wr_en && paddr_i == OFS_FRAME) begin
      lnk.k_val <= pwdata_i[F_K_VAL +: 5];
      lnk.f_val <= pwdata_i[F_F_VAL +: 5];
    end
  end

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  logic [1:0] pd_meta;
  logic [1:0] sync_meta;
  logic [NUM_CH*SMP_W+NUM_CH-1:0] adc_meta;
  logic [NUM_CH*SMP_W+NUM_CH-1:0] adc_sync;
  logic pd_pin;
  logic sync_n;
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      pd_meta <= '0;
      sync_meta <= 2'b11;
      adc_meta <= '0;
      adc_sync <= '0;
    end else begin
      pd_meta <= {pd_meta[0], power_down_pin_i};
      sync_meta <= {sync_meta[0], sync_n_i};
      // per-bit two-flop sync only; a real data path would use a sample strobe
      adc_meta <= {adc_ovr_i, adc_data_i};
      adc_sync <= adc_meta;
    end
  end
  assign pd_pin = pd_meta[1];
  assign sync_n = sync_meta[1];

  // ----------------------------------------------------------------
  // power control and clock divider
  // ----------------------------------------------------------------
  logic [CLK_DIV_W-1:0] div_cnt;
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      chip_pd_o <= 1'b0;
      ch_standby_o <= '0;
      sysref_buf_en_o <= 1'b1;
      low_freq_o <= 1'b0;
      dither_en_o <= '1;
      chopper_en_o <= '1;
    end else begin
      chip_pd_o <= cmn.global_pd || (pd_pin && !cmn.pin_is_standby);
      ch_standby_o <= ch_pd | {NUM_CH{cmn.standby || (pd_pin && cmn.pin_is_standby)}};
      sysref_buf_en_o <= !cmn.sysref_off;
      low_freq_o <= cmn.low_freq;
      dither_en_o <= ~dither_off;
      chopper_en_o <= ~chop_off;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (cfg_rst) begin
      div_cnt <= '0;
      sample_en_o <= 1'b0;
    end else begin
      // divide by clk_div+1; one-cycle enable marks each sample
      sample_en_o <= div_cnt == '0;
      div_cnt <= (div_cnt >= cmn.clk_div) ? '0 : div_cnt + 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // per-channel sample path
  // ----------------------------------------------------------------
  logic [SMP_W-1:0] ramp;
  logic [SMP_W-1:0] ramp_ch [NUM_CH];
  always_ff @(posedge sys_clk_i) begin
    if (cfg_rst || !test_en) begin
      ramp <= '0;
    end else if (sample_en_o) begin
      ramp <= ramp + 1'b1;
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < NUM_CH; gi++) begin : g_ch
      logic [SMP_W-1:0] raw;
      logic [SMP_W-1:0] pat;
      logic [SMP_W-1:0] fmt;
      logic [SMP_W-1:0] rev;
      logic [SMP_W+GAIN_W:0] prod;
      logic [SMP_W-1:0] gained;
      logic [GAIN_W-1:0] g;
      always_ff @(posedge sys_clk_i) begin
        if (cfg_rst) begin
          ramp_ch[gi] <= '0;
        end else if (sample_en_o) begin
          // without align each channel's ramp is offset so lanes differ
          ramp_ch[gi] <= align ? ramp : ramp + SMP_W'(gi);
        end
      end
      assign raw = adc_sync[gi*SMP_W +: SMP_W];
      assign rev = {<<{fmt}};
      assign g = (gain[gi*GAIN_W +: GAIN_W] > GAIN_MAX) ? GAIN_MAX : gain[gi*GAIN_W +: GAIN_W];
      // gain ~ 1 + code/12, linear approximation of 0..6 dB
      assign prod = (SMP_W+GAIN_W+1)'($signed(raw)) * (SMP_W+GAIN_W+1)'(g);
      assign gained = gain_en[gi] ? raw + SMP_W'($signed(prod) / 12) : raw;
      always_comb begin
        unique case (pat_sel[gi*PAT_W +: PAT_W])
          PAT_ZERO: pat = '0;
          PAT_ONES: pat = '1;
          PAT_RAMP: pat = ramp_ch[gi];
          PAT_CUSTOM: pat = custom;
        endcase
      end
      always_comb begin
        fmt = test_en ? pat : gained;
        if (!test_en && cmn.offset_bin) begin
          fmt[SMP_W-1] = ~fmt[SMP_W-1];
        end
        if (cmn.ovr_lsb) begin
          fmt[0] = adc_sync[NUM_CH*SMP_W+gi];
        end
      end
      always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
          smp_o[gi*SMP_W +: SMP_W] <= '0;
          lane_bits_o[gi*SMP_W +: SMP_W] <= '0;
        end else if (sample_en_o) begin
          smp_o[gi*SMP_W +: SMP_W] <= fmt;
          lane_bits_o[gi*SMP_W +: SMP_W] <= lnk.msb_first ? fmt : rev;
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // link sequencing
  // ----------------------------------------------------------------
  acj_lnk_state_t st;
  logic [4:0] fcnt;
  logic [4:0] mfcnt;
  logic [1:0] dly;
  logic mf_end;
  logic [4:0] k_eff;
  logic [4:0] f_eff;
  assign k_eff = lnk.k_ovr ? lnk.k_val : K_DEFAULT;
  assign f_eff = lnk.f_ovr ? lnk.f_val : F_DEFAULT;
  assign mf_end = sample_en_o && (mfcnt + 1'b1 >= k_eff) && (fcnt + 1'b1 >= f_eff);

  always_ff @(posedge sys_clk_i) begin
    if (cfg_rst || st == LNK_CGS) begin
      fcnt <= '0;
      mfcnt <= '0;
    end else if (sample_en_o) begin
      fcnt <= (fcnt + 1'b1 >= f_eff) ? '0 : fcnt + 1'b1;
      if (fcnt + 1'b1 >= f_eff) begin
        mfcnt <= (mfcnt + 1'b1 >= k_eff) ? '0 : mfcnt + 1'b1;
      end
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (cfg_rst) begin
      st <= LNK_CGS;
      dly <= '0;
    end else if (!sync_n || lnk.sync_req) begin
      st <= LNK_CGS;
      dly <= '0;
    end else begin
      unique case (st)
        LNK_CGS: st <= lnk.skip_ila ? LNK_DATA : LNK_WAIT;
        LNK_WAIT: begin
          if (dly == lnk.ila_delay) begin
            st <= LNK_ILA;
          end else if (mf_end) begin
            dly <= dly + 1'b1;
          end
        end
        LNK_ILA: begin
          if (mf_end) begin
            st <= LNK_DATA;
          end
        end
        LNK_DATA: st <= LNK_DATA;
      endcase
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      idle_char_o <= IDLE_K28_5;
      send_idle_o <= 1'b1;
      send_ila_o <= 1'b0;
      align_chars_en_o <= 1'b0;
      scramble_en_o <= 1'b0;
      subclass_o <= SUBCLASS_RST;
      k_o <= K_DEFAULT;
      f_o <= F_DEFAULT;
    end else begin
      idle_char_o <= lnk.idle;
      send_idle_o <= st == LNK_CGS || st == LNK_WAIT;
      send_ila_o <= st == LNK_ILA;
      align_chars_en_o <= lnk.align_chars;
      scramble_en_o <= lnk.scramble;
      subclass_o <= lnk.subclass;
      k_o <= k_eff;
      f_o <= f_eff;
    end
  end

  // ----------------------------------------------------------------
  // read back
  // ----------------------------------------------------------------
  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = '0;
    unique case (paddr_i)
      OFS_COMMON: rd_mux = {22'h0, cmn.clk_div, cmn.ovr_lsb, cmn.low_freq, cmn.sysref_off,
                            cmn.offset_bin, cmn.pin_is_standby, cmn.standby, cmn.global_pd, 1'b0};
      OFS_CHAN: rd_mux = {16'h0, gain_en, ch_pd, chop_off, dither_off};
      OFS_GAIN: rd_mux = {16'h0, gain};
      OFS_TEST: rd_mux = {6'h0, align, test_en, pat_sel, 2'h0, custom};
      OFS_LINK: rd_mux = {13'h0, lnk.sync_req, lnk.f_ovr, lnk.k_ovr, lnk.ila_delay, lnk.subclass,
                          lnk.scramble, lnk.align_chars, lnk.skip_ila, lnk.msb_first, lnk.idle};
      OFS_FRAME: rd_mux = {19'h0, lnk.f_val, 3'h0, lnk.k_val};
      OFS_STATUS: rd_mux = {26'h0, !sync_n, pd_pin, st};
      default: rd_mux = '0;
    endcase
  end

  // one wait state: ready in the second access cycle
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      pready_o <= 1'b0;
      pslverr_o <= 1'b0;
      prdata_o <= '0;
    end else begin
      pready_o <= psel_i && penable_i && !pready_o;
      pslverr_o <= psel_i && penable_i && !pready_o && !known;
      prdata_o <= (rd_en && !pready_o) ? rd_mux : '0;
    end
  end

endmodule
`default_nettype wire

// ==== design/acj_pkg.sv ====
// acj_pkg: register map, field layout, reset values and link constants for the
// converter configuration and serial-link transmit control block.
// assumes: apb slave with 32-bit data, one aligned word per register.
package acj_pkg;

  // ----------------------------------------------------------------
  // geometry
  // ----------------------------------------------------------------
  localparam int unsigned NUM_CH = 4;
  localparam int unsigned SMP_W = 14;
  localparam int unsigned ADDR_W = 8;

  // ----------------------------------------------------------------
  // register byte offsets
  // ----------------------------------------------------------------
  localparam logic [ADDR_W-1:0] OFS_COMMON = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_CHAN = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_GAIN = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_TEST = 8'h0C;
  localparam logic [ADDR_W-1:0] OFS_LINK = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_FRAME = 8'h14;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h18;

  // ----------------------------------------------------------------
  // common register fields
  // ----------------------------------------------------------------
  localparam int unsigned B_SOFT_RESET = 0;
  localparam int unsigned B_GLOBAL_PD = 1;
  localparam int unsigned B_STANDBY = 2;
  localparam int unsigned B_PIN_IS_STANDBY = 3;
  localparam int unsigned B_OFFSET_BIN = 4;
  localparam int unsigned B_SYSREF_OFF = 5;
  localparam int unsigned B_LOW_FREQ = 6;
  localparam int unsigned B_OVR_LSB = 7;
  localparam int unsigned F_CLK_DIV = 8;
  localparam int unsigned CLK_DIV_W = 2;

  // ----------------------------------------------------------------
  // channel register fields, one nibble per channel group
  // ----------------------------------------------------------------
  localparam int unsigned F_DITHER_OFF = 0;
  localparam int unsigned F_CHOP_OFF = 4;
  localparam int unsigned F_CH_PD = 8;
  localparam int unsigned F_GAIN_EN = 12;
  // gain: 4 bits per channel, code 0..12 in 0.5 dB steps, 0 to 6 dB
  localparam int unsigned GAIN_W = 4;
  localparam logic [GAIN_W-1:0] GAIN_MAX = 4'hC;

  // ----------------------------------------------------------------
  // test register fields
  // ----------------------------------------------------------------
  localparam int unsigned F_CUSTOM = 0;
  localparam int unsigned F_PAT_SEL = 16;
  localparam int unsigned PAT_W = 2;
  localparam int unsigned B_TEST_EN = 24;
  localparam int unsigned B_ALIGN = 25;
  localparam logic [PAT_W-1:0] PAT_ZERO = 2'h0;
  localparam logic [PAT_W-1:0] PAT_ONES = 2'h1;
  localparam logic [PAT_W-1:0] PAT_RAMP = 2'h2;
  localparam logic [PAT_W-1:0] PAT_CUSTOM = 2'h3;

  // ----------------------------------------------------------------
  // link register fields
  // ----------------------------------------------------------------
  localparam int unsigned F_IDLE = 0;
  localparam int unsigned B_MSB_FIRST = 8;
  localparam int unsigned B_SKIP_ILA = 9;
  localparam int unsigned B_ALIGN_CHARS = 10;
  localparam int unsigned B_SCRAMBLE = 11;
  localparam int unsigned F_SUBCLASS = 12;
  localparam int unsigned F_ILA_DELAY = 14;
  localparam int unsigned B_K_OVR = 16;
  localparam int unsigned B_F_OVR = 17;
  localparam int unsigned B_SYNC_REQ = 18;
  localparam int unsigned F_K_VAL = 0;
  localparam int unsigned F_F_VAL = 8;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] IDLE_K28_5 = 8'hBC;
  localparam logic [1:0] SUBCLASS_RST = 2'h2;
  localparam logic [4:0] K_DEFAULT = 5'h09;
  localparam logic [4:0] F_DEFAULT = 5'h02;
  localparam logic [CLK_DIV_W-1:0] CLK_DIV_RST = 2'h0;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic global_pd;
    logic standby;
    logic pin_is_standby;
    logic offset_bin;
    logic sysref_off;
    logic low_freq;
    logic ovr_lsb;
    logic [CLK_DIV_W-1:0] clk_div;
  } acj_common_t;

  typedef struct packed {
    logic [7:0] idle;
    logic msb_first;
    logic skip_ila;
    logic align_chars;
    logic scramble;
    logic [1:0] subclass;
    logic [1:0] ila_delay;
    logic k_ovr;
    logic f_ovr;
    logic sync_req;
    logic [4:0] k_val;
    logic [4:0] f_val;
  } acj_link_t;

  typedef enum logic [3:0] {
    LNK_CGS = 4'b0001,
    LNK_WAIT = 4'b0010,
    LNK_ILA = 4'b0100,
    LNK_DATA = 4'b1000
  } acj_lnk_state_t;

endpackage

// ==== dv/acj_rx_model.sv ====
// acj_rx_model: stand-in for the link receiver that asks for code sync.
// assumes: bench raises req_i whenever the receiver should lose lock.
`timescale 1ns/1ps
`default_nettype none
module acj_rx_model (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  // control and link
  input wire logic req_i,
  output logic sync_n_o
);
  // no lock during reset, so the request stands until reset is over
  always_ff @(posedge sys_clk_i) begin
    sync_n_o <= rst_n_i && !req_i;
  end
endmodule
`default_nettype wire

// ==== dv/acj_config_sva.sv ====
// acj_config_sva: port-level checks of the configuration block.
// assumes: bound to acj_config, single clock, synchronous reset.
`timescale 1ns/1ps
`default_nettype none
module acj_config_sva
  import acj_pkg::*;
(
  // clock, reset, bus
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic [31:0] prdata_o,
  input wire logic pready_o,
  input wire logic pslverr_o,
  // pins and controls
  input wire logic power_down_pin_i,
  input wire logic sync_n_i,
  input wire logic chip_pd_o,
  input wire logic [NUM_CH-1:0] ch_standby_o,
  input wire logic sysref_buf_en_o,
  input wire logic [NUM_CH-1:0] dither_en_o,
  input wire logic [NUM_CH-1:0] chopper_en_o,
  input wire logic [7:0] idle_char_o,
  input wire logic send_idle_o,
  input wire logic send_ila_o,
  input wire logic [1:0] subclass_o,
  input wire logic [4:0] k_o,
  input wire logic [4:0] f_o
);
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n_i);
  // pins pass a 2-flop sync, so hold longer than the lag
  sequence s_sync_held; !sync_n_i [*6]; endsequence
  sequence s_pin_held; power_down_pin_i [*5]; endsequence
  a_rst_link: assert property (disable iff (1'b0)
    !rst_n_i |=> subclass_o == 2'h2 && k_o == 5'h09 && f_o == 5'h02) else $error("link reset value wrong");
  a_rst_analog: assert property (disable iff (1'b0)
    !rst_n_i |=> sysref_buf_en_o && dither_en_o == 4'hF && chopper_en_o == 4'hF) else $error("analog reset wrong");
  a_rst_power: assert property (disable iff (1'b0)
    !rst_n_i |=> !chip_pd_o && ch_standby_o == 4'h0 && idle_char_o == 8'hBC) else $error("power reset wrong");
  a_sync_idle: assert property (s_sync_held |-> send_idle_o)
    else $error("no idle pattern under sync request");
  a_pin_power: assert property (s_pin_held |-> chip_pd_o || ch_standby_o == 4'hF)
    else $error("power pin ignored");
  a_ila_excl: assert property (send_ila_o |-> !send_idle_o)
    else $error("alignment and idle together");
  a_ready_pulse: assert property (psel_i && penable_i && !pready_o |=> pready_o)
    else $error("bus answer late");
  a_err_zero: assert property (pslverr_o |-> pready_o && prdata_o == 32'h0000_0000)
    else $error("error response malformed");
  a_rd_idle: assert property (!pready_o |-> prdata_o == 32'h0000_0000 && !pslverr_o)
    else $error("read data outside answer");
endmodule
bind acj_config acj_config_sva u_sva (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .psel_i(psel_i),
  .penable_i(penable_i), .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
  .power_down_pin_i(power_down_pin_i), .sync_n_i(sync_n_i), .chip_pd_o(chip_pd_o),
  .ch_standby_o(ch_standby_o), .sysref_buf_en_o(sysref_buf_en_o), .dither_en_o(dither_en_o),
  .chopper_en_o(chopper_en_o), .idle_char_o(idle_char_o), .send_idle_o(send_idle_o),
  .send_ila_o(send_ila_o), .subclass_o(subclass_o), .k_o(k_o), .f_o(f_o));
`default_nettype wire

// ==== dv/tb_top.sv ====
// tb_top: self-checking bench for acj_config over apb.
// assumes: receiver model drives sync; bench drives pins and samples.
`timescale 1ns/1ps
`default_nettype none
module tb_top
  import acj_pkg::*;
;
  logic clk, rst_n, psel, penable, pwrite, pin, req, sync_n, pready, pslverr, chip_pd, sref, lowf, smp_en;
  logic sidle, sila, alen, scr;
  logic [7:0] paddr, idle;
  logic [31:0] pwdata, prdata;
  logic [55:0] adc, smp, exp_smp, lane;
  logic [3:0] ovr, stby, dith, chop;
  logic [1:0] subcl;
  logic [4:0] k, f;
  logic [32:0] q[$];
  int n_mismatch, checked;
  initial begin
    clk = 0;
    forever #4 clk = ~clk;
  end
  acj_rx_model u_rx (.sys_clk_i(clk), .rst_n_i(rst_n), .req_i(req), .sync_n_o(sync_n));
  acj_config u_dut (.sys_clk_i(clk), .rst_n_i(rst_n), .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
    .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
    .power_down_pin_i(pin), .sync_n_i(sync_n), .adc_data_i(adc), .adc_ovr_i(ovr), .chip_pd_o(chip_pd),
    .ch_standby_o(stby), .sysref_buf_en_o(sref), .low_freq_o(lowf), .sample_en_o(smp_en),
    .dither_en_o(dith), .chopper_en_o(chop), .smp_o(smp), .lane_bits_o(lane), .idle_char_o(idle),
    .send_idle_o(sidle), .send_ila_o(sila), .align_chars_en_o(alen), .scramble_en_o(scr),
    .subclass_o(subcl), .k_o(k), .f_o(f));
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    psel <= 1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1;
    do @(posedge clk); while (pready !== 1'b1);
    psel <= 0;
    penable <= 0;
    @(posedge clk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [32:0] e);
    q.push_back(e);
    apb(0, a, 32'h0000_0000);
  endtask
  task automatic smp_wait(input int n);
    repeat (n) begin
      do @(posedge clk); while (smp_en !== 1'b1);
    end
  endtask
  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // read answers are judged against the oldest note
  always @(posedge clk) begin
    if (pready === 1'b1 && pwrite === 1'b0 && q.size() > 0) chk({pslverr, prdata}, q.pop_front());
  end
  initial begin
    repeat (30000) @(posedge clk);
    n_mismatch++;
    end_of_test;
  end
  initial begin
    logic [31:0] v;
    logic [13:0] w, pv, wr;
    logic [1:0] d;
    int c;
    {rst_n, psel, penable, pwrite, pin, req, paddr, pwdata, adc, ovr} = '0;
    v = $urandom(5359);
    repeat (8) @(posedge clk);
    rst_n <= 1;
    @(posedge clk);
    // ---------------------------------------------------------------
    // defaults, unmapped place, hold and software reset
    // ---------------------------------------------------------------
    rd(OFS_COMMON, 33'h0_0000_0000);
    rd(OFS_CHAN, 33'h0_0000_0000);
    rd(OFS_LINK, 33'h0_0000_20BC);
    rd(OFS_FRAME, 33'h0_0000_0209);
    rd(8'h1C, 33'h1_0000_0000);
    chk({sref, chop, dith, subcl, k, f, idle}, {1'b1, 8'hFF, 2'h2, 5'h09, 5'h02, 8'hBC});
    v = $urandom & 32'h0003_BFFF;
    apb(1, OFS_FRAME, 32'h0000_0C05);
    apb(1, OFS_LINK, v);
    rd(OFS_LINK, {1'b0, v});
    chk({idle, alen, scr, subcl}, {v[7:0], v[10], v[11], v[13:12]});
    chk({k, f}, {v[16] ? 5'h05 : K_DEFAULT, v[17] ? 5'h0C : F_DEFAULT});
    apb(1, OFS_COMMON, 32'h0000_0001);
    rd(OFS_COMMON, 33'h0_0000_0000);
    rd(OFS_LINK, 33'h0_0000_20BC);
    rd(OFS_FRAME, 33'h0_0000_0209);
    apb(1, OFS_COMMON, 32'h0000_0066);
    chk({chip_pd, stby, sref, lowf}, {1'b1, 4'hF, 1'b0, 1'b1});
    for (int m = 0; m < 2; m++) begin
      apb(1, OFS_COMMON, m << 3);
      pin <= 1;
      repeat (5) @(posedge clk);
      chk({chip_pd, stby}, m ? 5'h0F : 5'h10);
      pin <= 0;
      repeat (5) @(posedge clk);
    end
    // ---------------------------------------------------------------
    // divider, test patterns, format and over-range
    // ---------------------------------------------------------------
    d = 2'($urandom_range(3));
    apb(1, OFS_COMMON, {22'h0, d, 8'h10});
    smp_wait(1);
    c = 0;
    do begin @(posedge clk); c++; end while (smp_en !== 1'b1);
    chk(c, d + 1);
    w = 14'($urandom);
    wr = {<<{w}};
    for (int p = 0; p < 4; p++) begin
      apb(1, OFS_TEST, 32'h0300_0000 | ({4{p[1:0]}} << 16) | w);
      pv = (p == 0) ? 14'h0000 : (p == 1) ? 14'h3FFF : w;
      smp_wait(4);
      if (p == 2) chk(smp, {4{smp[13:0]}});
      else chk(smp, {4{pv}});
    end
    chk(lane, {4{wr}});
    apb(1, OFS_LINK, 32'h0000_21BC);
    smp_wait(4);
    chk(lane, {4{w}});
    apb(1, OFS_TEST, 32'h0000_0000);
    adc <= 56'({$urandom, $urandom});
    ovr <= 4'($urandom);
    for (int o = 0; o < 2; o++) begin
      apb(1, OFS_COMMON, {22'h0, d, o[0], 7'h10});
      smp_wait(4);
      for (int i = 0; i < 4; i++) begin
        exp_smp[i*14+:14] = adc[i*14+:14] ^ 14'h2000;
        if (o) exp_smp[i*14] = ovr[i];
      end
      chk(smp, exp_smp);
    end
    // ---------------------------------------------------------------
    // gain only where enabled, dither and chopper disables
    // ---------------------------------------------------------------
    v = $urandom & 32'h0000_0FFF;
    apb(1, OFS_COMMON, 32'h0000_0000);
    apb(1, OFS_CHAN, 32'h0000_1000 | v);
    apb(1, OFS_GAIN, 32'h0000_00CC);
    adc <= {28'h0, 14'h0100, 14'h0100};
    smp_wait(4);
    chk(smp[27:0], {14'h0100, 14'h0200});
    chk({stby, chop, dith}, {v[11:8], ~v[7:0]});
    // ---------------------------------------------------------------
    // sync request, alignment sequence or its skip
    // ---------------------------------------------------------------
    for (int s = 0; s < 2; s++) begin
      d = 2'($urandom_range(3));
      apb(1, OFS_LINK, 32'h0000_20BC | (s << 9) | (d << 14));
      req <= 1;
      repeat (8) @(posedge clk);
      chk({sidle, idle}, {1'b1, 8'hBC});
      req <= 0;
      c = 0;
      for (int i = 1; i <= 2000; i++) begin
        @(posedge clk);
        if (sila === 1'b1 && c == 0) c = i;
      end
      // first alignment cycle: sync lag plus d multiframes of K*F samples
      chk(c, s ? 0 : 7 + K_DEFAULT * F_DEFAULT * d);
      chk({sidle, sila}, 2'b00);
    end
    apb(1, OFS_LINK, 32'h0004_20BC);
    rd(OFS_STATUS, 33'h0_0000_0001);
    chk(sidle, 1'b1);
    end_of_test;
  end
endmodule
`default_nettype wire
